// ### raw_cap_pkg.sv
// Constants, register map and types shared by the raw data capture port
package raw_cap_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets on the AXI4-Lite slave
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STOP = 8'h04;
  localparam logic [7:0] ADDR_THR = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_LUMA = 8'h20;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_EN = 0;
  localparam int CTL_CON = 1;
  localparam int CTL_FRAME = 2;
  localparam int CTL_CF1 = 3;
  localparam int CTL_CF2 = 4;
  localparam int CTL_DUAL = 5;
  localparam int CTL_FIDEN = 6;
  localparam int CTL_SSE = 7;
  localparam int STOP_H_LSB = 0;
  localparam int STOP_V_LSB = 16;
  localparam int STOP_W = 12;
  localparam int THR_W = 13;
  localparam int STAT_F1 = 0;
  localparam int STAT_F2 = 1;
  localparam int STAT_FRAME_COMPLETE_FLAG = 2;
  localparam int STAT_CCMP = 3;
  localparam int STAT_FID = 4;
  localparam int STAT_OVF = 5;
  localparam int STAT_STATE_LSB = 6;
  localparam int STAT_LVL_LSB = 16;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [STOP_W-1:0] STOP_RST = 12'h000;
  localparam logic [THR_W-1:0] THR_RST = 13'h0000;
  // ----------------------------------------------------------------
  // Buffer geometry
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 8;
  localparam int WORD_BYTES = 4;
  localparam int FIFO_BYTES_SINGLE = 5120;
  localparam int FIFO_BYTES_DUAL = 2560;
  localparam int PTR_W = 11;
  localparam logic [PTR_W-1:0] DEPTH_SINGLE = PTR_W'(FIFO_BYTES_SINGLE / WORD_BYTES);
  localparam logic [PTR_W-1:0] DEPTH_DUAL = PTR_W'(FIFO_BYTES_DUAL / WORD_BYTES);
  localparam logic [1:0] PACK_LAST = 2'h3;
  localparam logic [1:0] SYNC_VBLANKS = 2'h2;
  // ----------------------------------------------------------------
  // Bus answers and states
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_HALT = 2'b11
  } cap_state_t;
endpackage

// ### raw_data_video_capture.sv
// Raw data capture port: pin sampling, packing buffer, completion and AXI4-Lite registers
`timescale 1ns/1ps
// How it works
// - A sample is stored only on link clock edges with the qualifier high.
// - Samples follow the sender's clock; data values never steer capture.
// - With setup sync set, enabling waits for two vertical blanking intervals.
// - With setup sync clear, capture starts at once on enable.
// - Buffer holds 5120 bytes single-channel, 2560 bytes per channel dual.
// - A read-only register pops the next stored samples from the buffer.
// - Data-set size is 24 bits: horizontal stop low, vertical stop high.
// - Reaching the data-set size completes the block and sets its flag.
// - A luma DMA event pulses after each threshold count of stored samples.
// - On channel A with field ID enabled, field ID is sampled at block start.
// - With field ID, continuous, frame and field selects act as in video.
// - Without field ID, each block counts as one progressive frame.
// - Noncontinuous: halt after next frame unless frame-complete was cleared.
// - Single frame: halt after the block until frame-complete is cleared.
// - Continuous: flag every frame, keep capturing; both bits set is reserved.
// - Continuous capture runs while enabled; the DMA must buffer circularly.
// - Samples in a widened window are buffered exactly like window samples.
// - Blanking capture needs start line set and line counter reset by V=1.
// - No scaling or resampling filter touches raw samples.
module raw_data_video_capture #(
  parameter bit IS_CHANNEL_A = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clk_in,
  input wire logic [raw_cap_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic capture_qualifier_in,
  input wire logic vblank_in,
  input wire logic control_pin_3,
  output logic luma_dma_event,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import raw_cap_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic clk_m, clk_s, clk_d, qual_m, qual_s, vbl_m, vbl_s, vbl_d, fid_m, fid_s;
  logic [SAMPLE_W-1:0] data_m, data_s;
  always_ff @(posedge aclk) begin
    clk_m <= link_clk_in;
    clk_s <= clk_m;
    clk_d <= clk_s;
    qual_m <= capture_qualifier_in;
    qual_s <= qual_m;
    vbl_m <= vblank_in;
    vbl_s <= vbl_m;
    vbl_d <= vbl_s;
    fid_m <= control_pin_3;
    fid_s <= fid_m;
    data_m <= sample_in;
    data_s <= data_m;
  end
  // Data rides the same two stages as the clock, so it is stable at the found edge
  logic link_rise, vbl_rise;
  assign link_rise = clk_s && !clk_d;
  assign vbl_rise = vbl_s && !vbl_d;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [STOP_W-1:0] hstop_r, vstop_r;
  logic [THR_W-1:0] thr_r, new_cnt_r;
  logic f1_r, f2_r, frame_complete_flag_r, ccmp_r, ovf_r, fid_r;
  cap_state_t state_r;
  logic [1:0] vbl_cnt_r, pack_cnt_r;
  logic [23:0] data_set_counter_r;
  logic [23:0] pack_r;
  logic [31:0] mem [0:DEPTH_SINGLE-1];
  logic [PTR_W-1:0] wr_ptr_r, rd_ptr_r, lvl_r, depth;
  logic en, continuous_bit, frame, cf1, cf2, fid_en;
  assign en = ctrl_r[CTL_EN];
  assign continuous_bit = ctrl_r[CTL_CON];
  assign frame = ctrl_r[CTL_FRAME];
  assign cf1 = ctrl_r[CTL_CF1];
  assign cf2 = ctrl_r[CTL_CF2];
  assign fid_en = IS_CHANNEL_A && ctrl_r[CTL_FIDEN];
  assign depth = ctrl_r[CTL_DUAL] ? DEPTH_DUAL : DEPTH_SINGLE;

  // ----------------------------------------------------------------
  // Capture decisions
  // ----------------------------------------------------------------
  logic take, fid_now, field_ok, store, last, frame_done, halt_now;
  logic set_f1, set_f2, full, push, pop;
  logic [23:0] stop_total;
  logic [31:0] word;
  assign stop_total = {vstop_r, hstop_r};
  assign take = (state_r == ST_ACTIVE) && link_rise && qual_s;
  assign fid_now = (data_set_counter_r == 24'h0) ? fid_s : fid_r;
  assign field_ok = !fid_en || (fid_now ? cf2 : cf1);
  assign store = take && field_ok;
  assign last = take && (data_set_counter_r + 24'h1 == stop_total);
  // With field ID the frame ends on the last selected field
  assign frame_done = last && (!fid_en || (fid_now ? cf2 : (cf1 && !cf2)));
  // Reserved con=1 frame=1 is treated as single frame
  assign halt_now = frame_done && !(continuous_bit && !frame) && (frame || frame_complete_flag_r);
  assign set_f1 = last && fid_en && !fid_now && cf1;
  assign set_f2 = last && fid_en && fid_now && cf2;
  assign full = (lvl_r == depth);
  // Partial word at block end is flushed zero padded so blocks never merge
  assign push = store && ((pack_cnt_r == PACK_LAST) || last);
  always_comb begin
    word = {8'h00, pack_r};
    word[pack_cnt_r*SAMPLE_W +: SAMPLE_W] = data_s;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      vbl_cnt_r <= 2'h0;
    end else if (!en) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          vbl_cnt_r <= 2'h0;
          state_r <= ctrl_r[CTL_SSE] ? ST_SYNC : ST_ACTIVE;
        end
        ST_SYNC: begin
          if (vbl_rise) begin
            vbl_cnt_r <= vbl_cnt_r + 2'h1;
            if (vbl_cnt_r + 2'h1 == SYNC_VBLANKS) state_r <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (halt_now) state_r <= ST_HALT;
        end
        ST_HALT: begin
          if (!frame_complete_flag_r) state_r <= ST_ACTIVE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Counter restarts on each block and whenever capture is not running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_set_counter_r <= 24'h0;
      fid_r <= 1'b0;
    end else if (state_r != ST_ACTIVE) begin
      data_set_counter_r <= 24'h0;
    end else if (take) begin
      if (data_set_counter_r == 24'h0 && fid_en) fid_r <= fid_s;
      data_set_counter_r <= last ? 24'h0 : data_set_counter_r + 24'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_r != ST_ACTIVE) begin
      pack_r <= 24'h0;
      pack_cnt_r <= 2'h0;
    end else if (push || last) begin
      pack_r <= 24'h0;
      pack_cnt_r <= 2'h0;
    end else if (store) begin
      pack_r <= word[23:0];
      pack_cnt_r <= pack_cnt_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Buffer; a full buffer drops the word and flags overflow
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (push && !full) mem[wr_ptr_r] <= word;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      lvl_r <= '0;
    end else begin
      if (push && !full) wr_ptr_r <= (wr_ptr_r == depth - 11'h1) ? '0 : wr_ptr_r + 11'h1;
      if (pop) rd_ptr_r <= (rd_ptr_r == depth - 11'h1) ? '0 : rd_ptr_r + 11'h1;
      lvl_r <= lvl_r + PTR_W'(push && !full) - PTR_W'(pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      new_cnt_r <= '0;
      luma_dma_event <= 1'b0;
    end else begin
      luma_dma_event <= 1'b0;
      if (store) begin
        if (thr_r != '0 && new_cnt_r + 13'h1 >= thr_r) begin
          new_cnt_r <= '0;
          luma_dma_event <= 1'b1;
        end else begin
          new_cnt_r <= new_cnt_r + 13'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_have_r, w_have_r, do_write, ar_take;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, wmask, clr;
  logic [3:0] w_strb_r;
  assign do_write = aw_have_r && w_have_r && !bvalid;
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign clr = (do_write && aw_addr_r == ADDR_STAT) ? (w_data_r & wmask) : 32'h0;
  assign ar_take = arvalid && arready;
  assign pop = ar_take && araddr == ADDR_LUMA && lvl_r != '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_have_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid <= 1'b1;
        if (aw_addr_r == ADDR_CTRL || aw_addr_r == ADDR_STOP) bresp <= RESP_OKAY;
        else if (aw_addr_r == ADDR_THR || aw_addr_r == ADDR_STAT) bresp <= RESP_OKAY;
        else bresp <= RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      hstop_r <= STOP_RST;
      vstop_r <= STOP_RST;
      thr_r <= THR_RST;
    end else if (do_write) begin
      if (aw_addr_r == ADDR_CTRL) begin
        ctrl_r <= (ctrl_r & ~wmask[7:0]) | (w_data_r[7:0] & wmask[7:0]);
      end else if (aw_addr_r == ADDR_STOP) begin
        hstop_r <= (hstop_r & ~wmask[STOP_H_LSB +: STOP_W])
          | (w_data_r[STOP_H_LSB +: STOP_W] & wmask[STOP_H_LSB +: STOP_W]);
        vstop_r <= (vstop_r & ~wmask[STOP_V_LSB +: STOP_W])
          | (w_data_r[STOP_V_LSB +: STOP_W] & wmask[STOP_V_LSB +: STOP_W]);
      end else if (aw_addr_r == ADDR_THR) begin
        thr_r <= (thr_r & ~wmask[THR_W-1:0]) | (w_data_r[THR_W-1:0] & wmask[THR_W-1:0]);
      end
    end
  end

  // Status flags: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f1_r <= 1'b0;
      f2_r <= 1'b0;
      frame_complete_flag_r <= 1'b0;
      ccmp_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      f1_r <= set_f1 || (f1_r && !clr[STAT_F1]);
      f2_r <= set_f2 || (f2_r && !clr[STAT_F2]);
      frame_complete_flag_r <= frame_done || (frame_complete_flag_r && !clr[STAT_FRAME_COMPLETE_FLAG]);
      ccmp_r <= frame_done || (ccmp_r && !clr[STAT_CCMP]);
      ovf_r <= (push && full) || (ovf_r && !clr[STAT_OVF]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      if (araddr == ADDR_CTRL) rdata <= {24'h0, ctrl_r};
      else if (araddr == ADDR_STOP) rdata <= {4'h0, vstop_r, 4'h0, hstop_r};
      else if (araddr == ADDR_THR) rdata <= {19'h0, thr_r};
      else if (araddr == ADDR_STAT)
        rdata <= {5'h00, lvl_r, 8'h00, state_r, ovf_r, fid_r, ccmp_r, frame_complete_flag_r, f2_r, f1_r};
      else if (araddr == ADDR_COUNT) rdata <= {8'h00, data_set_counter_r};
      else if (araddr == ADDR_LUMA) rdata <= (lvl_r != '0) ? mem[rd_ptr_r] : 32'h0;
      else begin
        rdata <= 32'h0;
        rresp <= RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Checked against the pins, so a synchroniser stage lost or added shows up
  qual_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    store |-> $past(capture_qualifier_in, 2) && $past(link_clk_in, 2)
      && !$past(link_clk_in, 3) && state_r == ST_ACTIVE)
    else $error("sample stored without qualifier");
  data_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
    store |-> data_s == $past(sample_in, 2))
    else $error("stored sample differs from the pin at the link edge");
  fid_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && fid_en && data_set_counter_r == 24'h0) |=> fid_r == $past(control_pin_3, 3))
    else $error("field id not taken at block start");
  sync_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_SYNC && en) |=> (state_r == ST_ACTIVE) || (vbl_cnt_r < SYNC_VBLANKS) || !en)
    else $error("setup sync overran two blankings");
  nosync_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_IDLE && en && !ctrl_r[CTL_SSE]) |=> state_r == ST_ACTIVE || !en)
    else $error("capture did not start at once");
  depth_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lvl_r <= depth || $changed(ctrl_r[CTL_DUAL]))
    else $error("buffer level beyond its depth");
  stop_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_done && !clr[STAT_FRAME_COMPLETE_FLAG]) |=> frame_complete_flag_r && ccmp_r && data_set_counter_r == 24'h0)
    else $error("block end not flagged");
  dma_evt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (store && thr_r != '0 && new_cnt_r + 13'h1 == thr_r) |=> luma_dma_event ##1 !luma_dma_event)
    else $error("luma event missing at threshold");
  single_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_done && frame && en) |=> state_r == ST_HALT)
    else $error("single frame did not halt");
  cont_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_done && continuous_bit && !frame && en) |=> state_r == ST_ACTIVE)
    else $error("continuous capture stopped");
  resume_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_HALT && !frame_complete_flag_r && en) |=> state_r == ST_ACTIVE && data_set_counter_r == 24'h0)
    else $error("no resume after clear");
endmodule // raw_data_video_capture

// ### raw_src_model.sv
// Behavioural raw sample source that drives the capture port pins
`timescale 1ns/1ps
module raw_src_model (
  output logic link_clk_in,
  output logic [7:0] sample_in,
  output logic capture_qualifier_in,
  output logic vblank_in,
  output logic control_pin_3
);
  initial begin
    link_clk_in = 1'b0;
    sample_in = 8'h00;
    capture_qualifier_in = 1'b0;
    vblank_in = 1'b0;
    control_pin_3 = 1'b0;
  end
  // ----------------------------------------------------------------
  // One sender clock period, data set while the clock is low
  // ----------------------------------------------------------------
  // Link edges sit between system clock edges so pin and sampler never race
  task automatic send(input logic [7:0] v, input logic q);
    sample_in = v;
    capture_qualifier_in = q;
    #37;
    link_clk_in = 1'b1;
    #40;
    link_clk_in = 1'b0;
    #3;
  endtask
  // Clock stands still between bursts; the released bus never shows a stale value
  task automatic idle();
    sample_in = ~sample_in;
    capture_qualifier_in = 1'b0;
  endtask
  task automatic vblank_pulse();
    #37;
    vblank_in = 1'b1;
    #200;
    vblank_in = 1'b0;
    #43;
  endtask
  task automatic set_fid(input logic f);
    control_pin_3 = f;
  endtask
endmodule // raw_src_model

// ### raw_data_video_capture_bench.sv
// Self-checking bench for the raw data capture port
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end
module raw_data_video_capture_bench;
  import raw_cap_pkg::*;
  logic aclk, aresetn, link_clk_in, capture_qualifier_in, vblank_in, control_pin_3;
  logic [7:0] sample_in, awaddr, araddr;
  logic luma_dma_event, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int err_total, comparisons, ev_cnt, ev0;
  logic [7:0] exp_q[$];
  logic [31:0] d;
  logic [1:0] r, b_last;

  raw_data_video_capture uut (.aclk(aclk), .aresetn(aresetn), .link_clk_in(link_clk_in),
    .sample_in(sample_in), .capture_qualifier_in(capture_qualifier_in),
    .vblank_in(vblank_in), .control_pin_3(control_pin_3), .luma_dma_event(luma_dma_event),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  raw_src_model u_src (.link_clk_in(link_clk_in), .sample_in(sample_in),
    .capture_qualifier_in(capture_qualifier_in), .vblank_in(vblank_in),
    .control_pin_3(control_pin_3));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (luma_dma_event === 1'b1) ev_cnt++;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic timeout();
    err_total++;
    finish_test();
  endtask
  // Four samples to a word, first sample in the low byte
  function automatic logic [31:0] next_word();
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < 4; i++) w[8*i +: 8] = exp_q.pop_front();
    return w;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    b_last = bresp;
    bready <= 1'b0;
    if (n >= 100) timeout();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    v = rdata;
    s = rresp;
    rready <= 1'b0;
    if (n >= 100) timeout();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] s;
    rd(a, v, s);
    `CHK(v & m, e)
  endtask
  // Qualified samples with unqualified noise between them; keep=0 means they must be dropped
  task automatic blk(input int n, input bit keep);
    logic [7:0] v;
    for (int i = 0; i < n; i++) begin
      if ($urandom % 2) u_src.send(8'($urandom), 1'b0);
      v = 8'($urandom);
      u_src.send(v, 1'b1);
      if (keep) exp_q.push_back(v);
    end
    u_src.idle();
    repeat (6) @(posedge aclk);
  endtask
  task automatic drain(input int n);
    logic [31:0] v;
    logic [1:0] s;
    for (int i = 0; i < n; i++) begin
      rd(ADDR_LUMA, v, s);
      `CHK(v, next_word())
    end
  endtask
  task automatic stop_all();
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_STAT, 32'h2f);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
    err_total = 0;
    comparisons = 0;
    ev_cnt = 0;
    void'($urandom(32'h2da4));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h30, d, r);
    `CHK(r, RESP_SLVERR)
    wr(8'h30, 32'h5a);
    `CHK(b_last, RESP_SLVERR)
    rchk(ADDR_STAT, 32'hffffffff, 32'h0);
    // Continuous: two blocks back to back without clearing frame complete
    wr(ADDR_STOP, 32'h0000_0008);
    `CHK(b_last, RESP_OKAY)
    wr(ADDR_THR, 32'h4);
    wr(ADDR_CTRL, 32'h03);
    ev0 = ev_cnt;
    for (int b = 0; b < 2; b++) begin
      blk(8, 1);
      rchk(ADDR_STAT, 32'hcf, 32'h8c);
      rchk(ADDR_COUNT, 32'hffffff, 32'h0);
      drain(2);
    end
    `CHK(ev_cnt - ev0, 4)
    stop_all();
    // Upper half of the size must matter
    wr(ADDR_STOP, 32'h0001_0004);
    wr(ADDR_CTRL, 32'h03);
    blk(8, 1);
    rchk(ADDR_COUNT, 32'hffffff, 32'h8);
    rchk(ADDR_STAT, 32'h4, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    drain(2);
    // Single frame: halts, drops, resumes at counter zero once cleared
    wr(ADDR_STOP, 32'h0000_0004);
    wr(ADDR_CTRL, 32'h05);
    blk(4, 1);
    rchk(ADDR_STAT, 32'hcc, 32'hcc);
    blk(4, 0);
    rchk(ADDR_COUNT, 32'hffffff, 32'h0);
    rchk(ADDR_STAT, 32'h07ff0000, 32'h0001_0000);
    wr(ADDR_STAT, 32'h0c);
    rchk(ADDR_STAT, 32'hc0, 32'h80);
    blk(4, 1);
    rchk(ADDR_STAT, 32'h4, 32'h4);
    drain(2);
    stop_all();
    // Noncontinuous: one more frame after the flag, then halt
    wr(ADDR_CTRL, 32'h01);
    blk(4, 1);
    wr(ADDR_STAT, 32'h04);
    blk(4, 1);
    rchk(ADDR_STAT, 32'hc4, 32'h84);
    blk(4, 1);
    rchk(ADDR_STAT, 32'hc4, 32'hc4);
    blk(4, 0);
    drain(3);
    stop_all();
    // Setup sync waits for two blanking intervals
    wr(ADDR_CTRL, 32'h83);
    blk(4, 0);
    rchk(ADDR_STAT, 32'hc0, 32'h40);
    u_src.vblank_pulse();
    rchk(ADDR_STAT, 32'hc0, 32'h40);
    u_src.vblank_pulse();
    rchk(ADDR_STAT, 32'hc0, 32'h80);
    blk(4, 1);
    drain(1);
    stop_all();
    // Field id sampled at block start on channel A
    u_src.set_fid(1'b1);
    wr(ADDR_CTRL, 32'h5b);
    blk(4, 1);
    rchk(ADDR_STAT, 32'h16, 32'h16);
    drain(1);
    stop_all();
    // Field 1 only: field 2 blocks are counted but never stored
    u_src.set_fid(1'b0);
    wr(ADDR_CTRL, 32'h4b);
    blk(4, 1);
    rchk(ADDR_STAT, 32'h17, 32'h05);
    u_src.set_fid(1'b1);
    blk(4, 0);
    rchk(ADDR_STAT, 32'h07ff0000, 32'h0001_0000);
    drain(1);
    stop_all();
    // Reserved mode acts as single frame; dual depth; threshold 0 gives no events
    wr(ADDR_THR, 32'h0);
    wr(ADDR_CTRL, 32'h27);
    ev0 = ev_cnt;
    blk(4, 1);
    rchk(ADDR_STAT, 32'hcc, 32'hcc);
    `CHK(ev_cnt - ev0, 0)
    drain(1);
    stop_all();
    finish_test();
  end
  initial begin
    #900us;
    timeout();
  end
endmodule // raw_data_video_capture_bench
